/* rtl/wel_wake_enable.sv */
// Wake source enable logic with a classic Wishbone register slave.
`timescale 1ns/100ps

// Operation
// R1: Gpio wake enable register, cleared by standby reset.
// R2: Bits 0..7 gate gpio lines 50..57.
// R3: Wake output low when status, enable, global set.
// R4: Disabled source still recorded, never drives wake.
// R5: Enables survive main, soft and PCI resets.
// R6: Interrupt wake enable register, cleared by standby reset.
// R7: Bits 0..7 are parallel/serial2/serial1/floppy/mouse/kbd/wdt/smbus.
// R8: Status bus set for enabled raised source.
// R9: Status bus never set for disabled source.
// R10: Offset 10 reads current management interrupt inputs.
// R11: Enable reads return last write or zero.

module wel_wake_enable (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [7:0]  GPIO_WAKE_IN,
    input  wire logic [7:0]  IRQ_SRC_IN,
    input  wire logic [7:0]  SMI_IN,
    input  wire logic        MAIN_POR,
    input  wire logic        SOFT_RST,
    input  wire logic        PCI_RST,
    output logic             WAKE_EVENT_OUT_N,
    output logic      [7:0]  WAKE_STATUS_BUS,
    output logic             IRQ
);

    // ==================================================================
    // State
    typedef struct packed {
        logic [7:0] gpio_wake_enable_bank_e;
        logic [7:0] interrupt_wake_enable;
        logic       global_wake_enable;
        logic [7:0] gpio_sts;
        logic [7:0] gpio_prev;
        logic [7:0] smi_prev;
        logic [3:0] irq_sts;
        logic [3:0] irq_mask;
        logic       ack;
        logic [7:0] rdata;
        logic       wake_n;
        logic [7:0] status_bus;
        logic       irq;
    } wel_state_s;

    wel_state_s q;
    wel_state_s d;

    // ==================================================================
    // Input synchronisers
    logic [26:0] raw_in;
    logic [26:0] sync_in;
    logic [7:0]  gpio_s;
    logic [7:0]  irq_s;
    logic [7:0]  smi_s;
    logic        main_rst_s;

    assign raw_in = {PCI_RST, SOFT_RST, MAIN_POR,
                     SMI_IN, IRQ_SRC_IN, GPIO_WAKE_IN};

    wel_sync #(
        .W (wel_pkg::SYNC_W)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RST),
        .din  (raw_in),
        .dout (sync_in)
    );

    assign gpio_s = sync_in[wel_pkg::SYNC_GPIO_LSB +: 8];
    assign irq_s  = sync_in[wel_pkg::SYNC_IRQ_LSB +: 8];
    assign smi_s  = sync_in[wel_pkg::SYNC_SMI_LSB +: 8];

    // Any of the main-power resets; none of them reaches the enables.
    assign main_rst_s = sync_in[wel_pkg::SYNC_MAIN_POR_BIT]
                      | sync_in[wel_pkg::SYNC_SOFT_RST_BIT]
                      | sync_in[wel_pkg::SYNC_PCI_RST_BIT]; // R5

    // ==================================================================
    // Bus decode
    logic       req;
    logic       wr;
    logic       rd;
    logic [5:0] idx;
    logic [7:0] wdata;

    assign idx   = WB_ADR_I[7:2];
    assign wdata = WB_DAT_I[7:0];
    // The ack flop blocks a second action on the same held request.
    assign req   = WB_CYC_I & WB_STB_I & ~q.ack;
    assign wr    = req & WB_WE_I & WB_SEL_I[0];
    assign rd    = req & ~WB_WE_I;

    // ==================================================================
    // Next state
    logic [7:0] gpio_rise;
    logic [7:0] gpio_clr;
    logic [3:0] irq_clr;
    logic [3:0] events;
    logic [7:0] rd_mux;

    always_comb begin
        d = q;

        // Bus handshake: one ack per request, dropped next cycle.
        d.ack = req;

        // Register writes.
        gpio_clr = 8'h00;
        irq_clr  = 4'h0;
        if (wr) begin
            case (idx)
                wel_pkg::IDX_GPIO_WAKE_EN: begin
                    d.gpio_wake_enable_bank_e = wdata; // R1
                end
                wel_pkg::IDX_INT_WAKE_EN: begin
                    d.interrupt_wake_enable = wdata; // R6
                end
                wel_pkg::IDX_WAKE_CTRL: begin
                    d.global_wake_enable =
                        wdata[wel_pkg::CTRL_GLOBAL_EN_BIT];
                end
                wel_pkg::IDX_GPIO_WAKE_STS: begin
                    gpio_clr = wdata;
                end
                wel_pkg::IDX_IRQ_STATUS: begin
                    irq_clr = wdata[3:0];
                end
                wel_pkg::IDX_IRQ_MASK: begin
                    d.irq_mask = wdata[3:0];
                end
                default: begin
                    d.irq_mask = q.irq_mask;
                end
            endcase
        end

        // Gpio wake status records edges whatever the enable holds.
        gpio_rise   = gpio_s & ~q.gpio_prev;
        d.gpio_prev = gpio_s;
        // A new edge wins over a write-one-to-clear in the same cycle.
        d.gpio_sts  = (q.gpio_sts & ~gpio_clr) | gpio_rise; // R4

        // Bit n of the enable gates gpio line 50+n onto the wake output.
        d.wake_n = ~(q.global_wake_enable
                     & (|(q.gpio_sts & q.gpio_wake_enable_bank_e))); // R2 R3

        // Each bit follows its source only while enabled.
        d.status_bus = irq_s & q.interrupt_wake_enable; // R7 R8 R9

        // Events for the local interrupt.
        d.smi_prev = smi_s;
        events = 4'h0;
        events[wel_pkg::EV_GPIO_WAKE_BIT]  = |gpio_rise;
        events[wel_pkg::EV_WAKE_OUT_BIT]   = q.wake_n & ~d.wake_n;
        events[wel_pkg::EV_STATUS_BUS_BIT] =
            |(d.status_bus & ~q.status_bus);
        events[wel_pkg::EV_SMI_CHANGE_BIT] = smi_s != q.smi_prev;

        // Main resets clear only the local interrupt state.
        if (main_rst_s) begin
            d.irq_sts  = wel_pkg::RST_IRQ_STATUS;
            d.irq_mask = wel_pkg::RST_IRQ_MASK;
        end else begin
            d.irq_sts = (q.irq_sts & ~irq_clr) | events;
        end
        d.irq = |(d.irq_sts & d.irq_mask);

        // Read data, registered so it stands with the ack.
        rd_mux = 8'h00;
        case (idx)
            wel_pkg::IDX_GPIO_WAKE_EN: begin
                rd_mux = q.gpio_wake_enable_bank_e; // R11
            end
            wel_pkg::IDX_INT_WAKE_EN: begin
                rd_mux = q.interrupt_wake_enable; // R11
            end
            wel_pkg::IDX_SMI_STATUS: begin
                rd_mux = smi_s; // R10
            end
            wel_pkg::IDX_WAKE_CTRL: begin
                rd_mux[wel_pkg::CTRL_GLOBAL_EN_BIT] =
                    q.global_wake_enable;
            end
            wel_pkg::IDX_GPIO_WAKE_STS: begin
                rd_mux = q.gpio_sts;
            end
            wel_pkg::IDX_IRQ_STATUS: begin
                rd_mux[3:0] = q.irq_sts;
            end
            wel_pkg::IDX_IRQ_MASK: begin
                rd_mux[3:0] = q.irq_mask;
            end
            wel_pkg::IDX_WAKE_STATE: begin
                rd_mux = q.status_bus;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
        if (rd) begin
            d.rdata = rd_mux;
        end
    end

    // ==================================================================
    // Registers
    // RST is the standby-power reset; it alone clears the enables.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            q.gpio_wake_enable_bank_e <= wel_pkg::RST_GPIO_WAKE_EN; // R1
            q.interrupt_wake_enable   <= wel_pkg::RST_INT_WAKE_EN; // R6
            q.global_wake_enable      <= wel_pkg::RST_GLOBAL_EN;
            q.gpio_sts                <= wel_pkg::RST_GPIO_STS;
            q.gpio_prev               <= wel_pkg::RST_PREV;
            q.smi_prev                <= wel_pkg::RST_PREV;
            q.irq_sts                 <= wel_pkg::RST_IRQ_STATUS;
            q.irq_mask                <= wel_pkg::RST_IRQ_MASK;
            q.ack                     <= wel_pkg::RST_ACK;
            q.rdata                   <= wel_pkg::RST_RDATA;
            q.wake_n                  <= wel_pkg::RST_WAKE_N;
            q.status_bus              <= wel_pkg::RST_STATUS_BUS;
            q.irq                     <= wel_pkg::RST_IRQ;
        end else begin
            q <= d;
        end
    end

    // ==================================================================
    // Outputs
    assign WB_ACK_O         = q.ack;
    assign WB_DAT_O         = {24'h000000, q.rdata};
    assign WAKE_EVENT_OUT_N = q.wake_n;
    assign WAKE_STATUS_BUS  = q.status_bus;
    assign IRQ              = q.irq;

endmodule

/* rtl/wel_pkg.sv */
// Package of register indices, field positions and reset values.
package wel_pkg;

    // ==================================================================
    // Register indices; the byte address on the bus is four times these.
    localparam logic [5:0] IDX_GPIO_WAKE_EN  = 6'h0e;
    localparam logic [5:0] IDX_INT_WAKE_EN   = 6'h0f;
    localparam logic [5:0] IDX_SMI_STATUS    = 6'h10;
    localparam logic [5:0] IDX_WAKE_CTRL     = 6'h20;
    localparam logic [5:0] IDX_GPIO_WAKE_STS = 6'h21;
    localparam logic [5:0] IDX_IRQ_STATUS    = 6'h22;
    localparam logic [5:0] IDX_IRQ_MASK      = 6'h23;
    localparam logic [5:0] IDX_WAKE_STATE    = 6'h24;

    // ==================================================================
    // Widths.
    localparam int REG_W   = 8;
    localparam int IRQ_W   = 4;
    localparam int SYNC_W  = 27;

    // ==================================================================
    // Field positions.
    localparam int CTRL_GLOBAL_EN_BIT = 0;
    localparam int EV_GPIO_WAKE_BIT   = 0;
    localparam int EV_WAKE_OUT_BIT    = 1;
    localparam int EV_STATUS_BUS_BIT  = 2;
    localparam int EV_SMI_CHANGE_BIT  = 3;
    localparam int SYNC_GPIO_LSB      = 0;
    localparam int SYNC_IRQ_LSB       = 8;
    localparam int SYNC_SMI_LSB       = 16;
    localparam int SYNC_MAIN_POR_BIT  = 24;
    localparam int SYNC_SOFT_RST_BIT  = 25;
    localparam int SYNC_PCI_RST_BIT   = 26;

    // ==================================================================
    // Values after reset.
    localparam logic [7:0]  RST_GPIO_WAKE_EN = 8'h00;
    localparam logic [7:0]  RST_INT_WAKE_EN  = 8'h00;
    localparam logic [7:0]  RST_GPIO_STS     = 8'h00;
    localparam logic [3:0]  RST_IRQ_STATUS   = 4'h0;
    localparam logic [3:0]  RST_IRQ_MASK     = 4'h0;
    localparam logic        RST_GLOBAL_EN    = 1'h0;
    localparam logic [26:0] RST_SYNC         = 27'h0000000;
    localparam logic [7:0]  RST_PREV         = 8'h00;
    localparam logic [7:0]  RST_RDATA        = 8'h00;
    localparam logic [7:0]  RST_STATUS_BUS   = 8'h00;
    localparam logic        RST_ACK          = 1'h0;
    localparam logic        RST_WAKE_N       = 1'h1;
    localparam logic        RST_IRQ          = 1'h0;

endpackage

/* rtl/wel_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps

module wel_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // ==================================================================
    // State
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } wel_sync_s;

    wel_sync_s q;
    wel_sync_s d;

    // The first stage feeds only the second stage.
    always_comb begin
        d        = q;
        d.meta   = din;
        d.stable = q.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.stable;

endmodule

/* bench/wel_wake_enable_properties.sv */
// Concurrent checks on the ports of the wake enable block.
`timescale 1ns/100ps
module wel_wake_enable_properties (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic [7:0]  IRQ_SRC_IN,
    input wire logic [7:0]  SMI_IN,
    input wire logic        MAIN_POR,
    input wire logic        SOFT_RST,
    input wire logic        PCI_RST,
    input wire logic [7:0]  WAKE_STATUS_BUS
);
    // ========================================
    // Properties.
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic req;
    logic rd_take;
    assign req = WB_CYC_I && WB_STB_I;
    assign rd_take = req && !WB_ACK_O && !WB_WE_I;
    // Inputs pass two flops, so a read only shows a settled value.
    sequence smi_calm;
        $stable(SMI_IN)[*3];
    endsequence
    sequence bus_quiet;
        (!WB_ACK_O && $stable(IRQ_SRC_IN))[*4];
    endsequence
    a_ack_answer: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req))
        else $error("ack without request");
    a_dat_hold: assert property (!$past(rd_take) |-> $stable(WB_DAT_O))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (rd_take &&
        WB_ADR_I[7:2] > wel_pkg::IDX_WAKE_STATE |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_smi_read: assert property (smi_calm ##0 (rd_take &&
        WB_ADR_I[7:2] == wel_pkg::IDX_SMI_STATUS)
        |=> WB_DAT_O[7:0] == $past(SMI_IN)) else $error("smi read wrong");
    a_bus_gated: assert property (
        !(|(WAKE_STATUS_BUS & ~$past(IRQ_SRC_IN, 3))))
        else $error("status bus set without source");
    a_enable_kept: assert property (bus_quiet ##0
        (MAIN_POR || SOFT_RST || PCI_RST) |-> $stable(WAKE_STATUS_BUS))
        else $error("status bus moved on other reset");
endmodule

bind wel_wake_enable wel_wake_enable_properties
    wel_wake_enable_properties_inst (.*);

/* bench/wel_host_model.sv */
// Host wake logic that latches what the block reports.
`timescale 1ns/100ps
module wel_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wake_n,
    input  wire logic [7:0] status_bus,
    output logic            wake_seen,
    output logic [7:0]      status_seen
);
    // ========================================
    // Latched, because the host only needs to know a request came.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_seen <= 1'h0;
            status_seen <= 8'h00;
        end else begin
            wake_seen <= wake_seen | ~wake_n;
            status_seen <= status_seen | status_bus;
        end
    end
endmodule

/* bench/wel_wake_enable_tb.sv */
// Self-checking testbench for the wake enable block.
`timescale 1ns/100ps
module wel_wake_enable_tb;
    // ========================================
    // Stimulus and checks.
    logic        CORE_CLK = 1'h0, RST = 1'h1, WB_CYC_I = 1'h0;
    logic        WB_STB_I = 1'h0, WB_WE_I = 1'h0, MAIN_POR = 1'h0;
    logic        SOFT_RST = 1'h0, PCI_RST = 1'h0;
    logic [7:0]  WB_ADR_I = 8'h00, GPIO_WAKE_IN = 8'h00, rd;
    logic [7:0]  IRQ_SRC_IN = 8'h00, SMI_IN = 8'h00, WAKE_STATUS_BUS;
    logic [3:0]  WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic        WB_ACK_O, WAKE_EVENT_OUT_N, IRQ, wake_seen;
    logic [7:0]  bus_seen;
    int          fails = 0, checks_done = 0, ticks = 0;

    wel_wake_enable wel_wake_enable_inst (.*);
    wel_host_model wel_host_model_inst (.clk(CORE_CLK), .rst(RST),
        .wake_n(WAKE_EVENT_OUT_N), .status_bus(WAKE_STATUS_BUS),
        .wake_seen(wake_seen), .status_seen(bus_seen));

    initial begin
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    task automatic xfer(input logic we, input logic [7:0] a, d);
        @(posedge CORE_CLK);
        WB_CYC_I <= 1'h1;
        WB_STB_I <= 1'h1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= 4'h1;
        WB_DAT_I <= {24'h0, d};
        do @(posedge CORE_CLK); while (WB_ACK_O !== 1'h1);
        rd = WB_DAT_O[7:0];
        WB_CYC_I <= 1'h0;
        WB_STB_I <= 1'h0;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rc(input logic [7:0] a, e);
        xfer(1'h0, a, 8'h00);
        chk($sformatf("reg %h", a), rd, e);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        ticks <= ticks + 1;
        if (ticks == 6000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        cyc(6);
        RST <= 1'h0;
        rc(8'h38, 8'h00);
        rc(8'h3c, 8'h00);
        xfer(1'h1, 8'h38, 8'ha5);
        xfer(1'h1, 8'h3c, 8'h5a);
        xfer(1'h1, 8'hfc, 8'hff);
        rc(8'h38, 8'ha5);
        rc(8'h3c, 8'h5a);
        rc(8'hfc, 8'h00);
        IRQ_SRC_IN <= 8'hff;
        for (int i = 0; i < 8; i++) begin
            xfer(1'h1, 8'h3c, 8'h01 << i);
            cyc(4);
            chk("status_bus", WAKE_STATUS_BUS, 8'h01 << i);
        end
        chk("host_bus", bus_seen, 8'hff);
        xfer(1'h1, 8'h3c, 8'h00);
        cyc(3);
        chk("bus_gated", WAKE_STATUS_BUS, 8'h00);
        xfer(1'h1, 8'h80, 8'h01);
        xfer(1'h1, 8'h84, 8'hff);
        for (int i = 0; i < 8; i++) begin
            xfer(1'h1, 8'h38, 8'h01 << i);
            GPIO_WAKE_IN <= ~(8'h01 << i);
            cyc(6);
            chk("wake_off", WAKE_EVENT_OUT_N, 1'h1);
            rc(8'h84, ~(8'h01 << i));
            GPIO_WAKE_IN <= 8'hff;
            cyc(6);
            chk("wake_on", WAKE_EVENT_OUT_N, 1'h0);
            GPIO_WAKE_IN <= 8'h00;
            xfer(1'h1, 8'h84, 8'hff);
            cyc(2);
        end
        chk("host_wake", wake_seen, 1'h1);
        xfer(1'h1, 8'h38, 8'h01);
        GPIO_WAKE_IN <= 8'h01;
        cyc(6);
        chk("irq_masked", IRQ, 1'h0);
        xfer(1'h1, 8'h80, 8'h00);
        cyc(2);
        chk("wake_global", WAKE_EVENT_OUT_N, 1'h1);
        xfer(1'h1, 8'h8c, 8'h01);
        cyc(2);
        chk("irq_on", IRQ, 1'h1);
        xfer(1'h1, 8'h88, 8'h0f);
        cyc(2);
        chk("irq_clr", IRQ, 1'h0);
        xfer(1'h1, 8'h3c, 8'hc3);
        cyc(6);
        rc(8'h90, 8'hc3);
        rc(8'h80, 8'h00);
        rc(8'h8c, 8'h01);
        rc(8'h88, 8'h04);
        for (int k = 0; k < 3; k++) begin
            {MAIN_POR, SOFT_RST, PCI_RST} <= 3'h4 >> k;
            cyc(8);
            {MAIN_POR, SOFT_RST, PCI_RST} <= 3'h0;
            cyc(4);
            rc(8'h38, 8'h01);
            rc(8'h3c, 8'hc3);
        end
        SMI_IN <= 8'h96;
        cyc(4);
        rc(8'h40, 8'h96);
        rc(8'h88, 8'h08);
        rc(8'h8c, 8'h00);
        RST <= 1'h1;
        cyc(2);
        RST <= 1'h0;
        rc(8'h38, 8'h00);
        rc(8'h3c, 8'h00);
        conclude();
    end
endmodule
